// ===== design/qpc_core.sv
// Our own choice: the AHB-Lite register port.
module qpc_core #(
  parameter int PROG_DEPTH = 1024
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core timing
  output qpc_pkg::qpc_phase_t phase
);
  import qpc_pkg::*;

  localparam int AW = $clog2(PROG_DEPTH);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic run;
  logic [12:0] pc;
  logic [12:0] fetch_addr;
  logic [13:0] fetch_word;
  logic fetch_valid;
  logic [13:0] ir;
  logic ir_valid;
  logic [7:0] w_reg;
  logic [7:0] operand;
  logic [7:0] gpr [128];
  logic [7:0] sfr [16];
  logic [13:0] prog_mem [PROG_DEPTH];
  logic [AW-1:0] prog_addr;
  logic bus_we;
  logic [11:0] bus_addr;

  function automatic logic [7:0] read_cell(input qpc_cell_t c);
    logic [7:0] v;
    v = 8'h00; // RQ9
    if (c.kind == K_PCL) begin
      v = pc[7:0];
    end else if (c.kind == K_SFR) begin
      v = sfr[c.idx[3:0]];
    end else if (c.kind == K_GPR) begin
      v = gpr[c.idx];
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Phase generator
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= QPC_PH1;
    end else begin
      unique case (phase)
        QPC_PH1: phase <= QPC_PH2; // RQ1
        QPC_PH2: phase <= QPC_PH3;
        QPC_PH3: phase <= QPC_PH4;
        QPC_PH4: phase <= QPC_PH1;
        default: phase <= QPC_PH1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Decode and execute
  // ---------------------------------------------------------------
  logic is_movwf, is_clrf, is_addwf, is_movf, is_movlw, is_goto;
  logic [7:0] direct_addr;
  qpc_cell_t core_cell;
  logic exec_q4;
  logic core_we;
  logic w_we;
  logic z_we;
  logic [7:0] result;
  logic [8:0] sum;
  logic take_branch;
  logic [12:0] branch_pc;

  always_comb begin
    is_movwf = (ir[13:7] == OP_MOVWF);
    is_clrf = (ir[13:7] == OP_CLRF);
    is_addwf = (ir[13:8] == OP_ADDWF);
    is_movf = (ir[13:8] == OP_MOVF);
    is_movlw = (ir[13:10] == OP_MOVLW);
    is_goto = (ir[13:11] == OP_GOTO);
    direct_addr = {sfr[I_STATUS][STATUS_PAGE_BIT], ir[6:0]}; // RQ10
    core_cell = qpc_resolve(direct_addr, sfr[I_POINTER]);
    exec_q4 = run && ir_valid && (phase == QPC_PH4);
    sum = {1'b0, operand} + {1'b0, w_reg};
    result = 8'h00;
    if (is_movwf) begin
      result = w_reg;
    end else if (is_addwf) begin
      result = sum[7:0];
    end else if (is_movf) begin
      result = operand;
    end else if (is_movlw) begin
      result = ir[7:0];
    end
    core_we = exec_q4 && (is_movwf || is_clrf || ((is_addwf || is_movf) && ir[7])); // RQ7
    w_we = exec_q4 && (is_movlw || ((is_addwf || is_movf) && !ir[7]));
    z_we = exec_q4 && (is_clrf || is_addwf || is_movf);
    if (is_goto) begin
      branch_pc = {sfr[I_LATCH][4:3], ir[10:0]};
    end else begin
      branch_pc = {sfr[I_LATCH][4:0], result}; // RQ11
    end
    take_branch = exec_q4 && (is_goto || (core_we && core_cell.kind == K_PCL)); // RQ5
  end

  // Operand is sampled in phase two so the later phases see a stable value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      operand <= 8'h00;
    end else if (run && ir_valid && phase == QPC_PH2) begin
      operand <= read_cell(core_cell); // RQ7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_reg <= 8'h00;
    end else if (w_we) begin
      w_reg <= result;
    end
  end

  // ---------------------------------------------------------------
  // Program counter and fetch pipeline
  // ---------------------------------------------------------------
  logic bus_pcl_we;
  qpc_cell_t bus_cell;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= 13'h0000;
      fetch_addr <= 13'h0000;
    end else if (take_branch) begin
      pc <= branch_pc; // RQ5
    end else if (bus_pcl_we) begin
      pc <= {sfr[I_LATCH][4:0], hwdata[7:0]}; // RQ11
    end else if (run && phase == QPC_PH1) begin
      pc <= pc + 13'h0001; // RQ2
      fetch_addr <= pc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_word <= INSTR_NOP;
      fetch_valid <= 1'b0;
    end else if (!run || bus_pcl_we) begin
      fetch_valid <= 1'b0;
    end else if (phase == QPC_PH4) begin
      fetch_word <= prog_mem[fetch_addr[AW-1:0]]; // RQ3
      fetch_valid <= !take_branch; // RQ5
    end
  end

  // The holding register takes the word fetched one cycle before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir <= INSTR_NOP;
      ir_valid <= 1'b0;
    end else if (run && phase == QPC_PH1) begin
      ir <= fetch_word; // RQ6
      ir_valid <= fetch_valid; // RQ4
    end
  end

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  logic bus_data_we;

  always_comb begin
    bus_data_we = bus_we && (bus_addr[11:10] == 2'b00);
    bus_cell = qpc_resolve(bus_addr[9:2], sfr[I_POINTER]);
    bus_pcl_we = bus_data_we && bus_cell.kind == K_PCL;
  end

  // Bus writes land first so a core write to the same cell in that edge wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) begin
        sfr[i] <= SFR_RESET;
      end
      sfr[I_STATUS] <= STATUS_RESET;
    end else begin
      if (bus_data_we && bus_cell.kind == K_SFR) begin
        if (bus_cell.idx[3:0] == I_STATUS) begin
          sfr[I_STATUS] <= (hwdata[7:0] & ~STATUS_RO_MASK) | (sfr[I_STATUS] & STATUS_RO_MASK);
        end else begin
          sfr[bus_cell.idx[3:0]] <= hwdata[7:0];
        end
      end
      if (core_we && core_cell.kind == K_SFR) begin
        if (core_cell.idx[3:0] == I_STATUS) begin
          sfr[I_STATUS] <= (result & ~STATUS_RO_MASK) | (sfr[I_STATUS] & STATUS_RO_MASK);
        end else begin
          sfr[core_cell.idx[3:0]] <= result; // RQ7
        end
      end
      // Zero flag from the result overrides a write of the status itself.
      if (z_we) begin
        sfr[I_STATUS][STATUS_Z_BIT] <= (result == 8'h00);
      end
    end
  end

  // General RAM holds only data, so it is left without reset.
  always_ff @(posedge hclk) begin
    if (bus_data_we && bus_cell.kind == K_GPR) begin
      gpr[bus_cell.idx] <= hwdata[7:0]; // RQ13
    end
    if (core_we && core_cell.kind == K_GPR) begin
      gpr[core_cell.idx] <= result; // RQ13
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  logic take;
  qpc_cell_t bus_rd_cell;

  always_comb begin
    take = hsel && hready && htrans[1];
    bus_rd_cell = qpc_resolve(haddr[9:2], sfr[I_POINTER]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_we <= 1'b0;
      bus_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      bus_we <= take && hwrite;
      bus_addr <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is formed in the address phase; a core write in that same
  // edge is not seen by this read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[11:10] == 2'b00) begin
        hrdata <= {24'h000000, read_cell(qpc_resolve(haddr[9:2], sfr[I_POINTER]))}; // RQ9
      end else if (haddr == BUS_CTRL) begin
        hrdata <= {31'h00000000, run};
      end else if (haddr == BUS_PROG_ADDR) begin
        hrdata[AW-1:0] <= prog_addr;
      end else if (haddr == BUS_PROG_DATA) begin
        hrdata <= {18'h00000, prog_mem[prog_addr]};
      end else if (haddr == BUS_STATE) begin
        hrdata <= {4'h0, phase, w_reg, 3'h0, pc};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 1'b0;
      prog_addr <= '0;
    end else if (bus_we) begin
      if (bus_addr == BUS_CTRL) begin
        run <= hwdata[0];
      end else if (bus_addr == BUS_PROG_ADDR) begin
        prog_addr <= hwdata[AW-1:0];
      end else if (bus_addr == BUS_PROG_DATA) begin
        prog_addr <= prog_addr + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (bus_we && bus_addr == BUS_PROG_DATA) begin
      prog_mem[prog_addr] <= hwdata[13:0];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_phase_cycle;
    @(posedge hclk) disable iff (!hresetn)
      phase == QPC_PH1 |-> ##1 phase == QPC_PH2 ##1 phase == QPC_PH3
        ##1 phase == QPC_PH4 ##1 phase == QPC_PH1;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken"); // RQ1

  property p_pc_step;
    @(posedge hclk) disable iff (!hresetn)
      (run && phase == QPC_PH1 && !bus_pcl_we) |=> pc == $past(pc) + 13'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not advance in phase one"); // RQ2

  property p_fetch_q4;
    @(posedge hclk) disable iff (!hresetn)
      phase != QPC_PH4 |=> $stable(fetch_word);
  endproperty
  a_fetch_q4: assert property (p_fetch_q4) else $error("fetch outside phase four"); // RQ3

  property p_ir_q1;
    @(posedge hclk) disable iff (!hresetn)
      phase != QPC_PH1 |=> $stable(ir) && $stable(ir_valid);
  endproperty
  a_ir_q1: assert property (p_ir_q1) else $error("holding register moved outside phase one"); // RQ6

  property p_write_q4;
    @(posedge hclk) disable iff (!hresetn)
      core_we |-> phase == QPC_PH4 && $past(phase, 2) == QPC_PH2;
  endproperty
  a_write_q4: assert property (p_write_q4) else $error("core write outside phase four"); // RQ7

  property p_branch_flush;
    @(posedge hclk) disable iff (!hresetn)
      take_branch |-> ##2 !ir_valid [*4];
  endproperty
  a_branch_flush: assert property (p_branch_flush) else $error("word after branch not discarded"); // RQ5

  property p_unimpl_zero;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && haddr[11:10] == 2'b00
        && bus_rd_cell.kind == K_NONE) |=> hrdata == 32'h00000000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("empty location read nonzero"); // RQ9

  property p_pcl_latch;
    @(posedge hclk) disable iff (!hresetn)
      (take_branch && !is_goto) |=> pc[12:8] == $past(sfr[I_LATCH][4:0]);
  endproperty
  a_pcl_latch: assert property (p_pcl_latch) else $error("pc high not from latch"); // RQ11

  property p_direct_bank;
    @(posedge hclk) disable iff (!hresetn)
      ir_valid |-> direct_addr[7] == sfr[I_STATUS][STATUS_PAGE_BIT];
  endproperty
  a_direct_bank: assert property (p_direct_bank) else $error("bank not from page bit"); // RQ10

endmodule

// ===== pkg/qpc_pkg.sv
// How it works
// RQ1 - Oscillator divided into four rotating phases
// RQ2 - Program counter advances in phase one
// RQ3 - Program word captured in phase four
// RQ4 - Fetch overlaps execute, one instruction per cycle
// RQ5 - Program counter changes cost two cycles
// RQ6 - Holding register loads in phase one
// RQ7 - Operand read phase two, result written four
// RQ8 - Indirect location reaches cell named by pointer
// RQ9 - Empty locations read zero, ignore writes
// RQ10 - Page select bit chooses bank for direct
// RQ11 - High latch feeds counter on low write
// RQ12 - Core registers shared; F0h-FFh mirror 70h-7Fh
// RQ13 - General RAM at 20h-7Fh and A0h-BFh
package qpc_pkg;

  // ---------------------------------------------------------------
  // Phases and data-memory map
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    QPC_PH1 = 4'b0001,
    QPC_PH2 = 4'b0010,
    QPC_PH3 = 4'b0100,
    QPC_PH4 = 4'b1000
  } qpc_phase_t;

  localparam logic [7:0] A_INDIRECT = 8'h00;
  localparam logic [7:0] A_TIMER0 = 8'h01;
  localparam logic [7:0] A_PCL = 8'h02;
  localparam logic [7:0] A_STATUS = 8'h03;
  localparam logic [7:0] A_POINTER = 8'h04;
  localparam logic [7:0] A_PORT = 8'h05;
  localparam logic [7:0] A_LATCH = 8'h0A;
  localparam logic [7:0] A_INTCTL = 8'h0B;
  localparam logic [7:0] A_PIFLAGS = 8'h0C;
  localparam logic [7:0] A_ADC_RESULT = 8'h1E;
  localparam logic [7:0] A_ADCTLA = 8'h1F;
  localparam logic [7:0] A_OPTION = 8'h81;
  localparam logic [7:0] A_PORTDIR = 8'h85;
  localparam logic [7:0] A_PIEN = 8'h8C;
  localparam logic [7:0] A_PWRFLAGS = 8'h8E;
  localparam logic [7:0] A_OSCTRIM = 8'h8F;
  localparam logic [7:0] A_ADCTLB = 8'h9F;
  localparam logic [7:0] A_GPR0_LO = 8'h20;
  localparam logic [7:0] A_GPR0_HI = 8'h7F;
  localparam logic [7:0] A_GPR1_LO = 8'hA0;
  localparam logic [7:0] A_GPR1_HI = 8'hBF;
  localparam logic [7:0] A_MIRROR_LO = 8'hF0;
  localparam logic [7:0] BANK_MASK = 8'h7F;
  localparam logic [6:0] GPR1_BASE = 7'd96;

  localparam logic [3:0] I_TIMER0 = 4'd0;
  localparam logic [3:0] I_STATUS = 4'd1;
  localparam logic [3:0] I_POINTER = 4'd2;
  localparam logic [3:0] I_PORT = 4'd3;
  localparam logic [3:0] I_LATCH = 4'd4;
  localparam logic [3:0] I_INTCTL = 4'd5;
  localparam logic [3:0] I_PIFLAGS = 4'd6;
  localparam logic [3:0] I_ADC_RESULT = 4'd7;
  localparam logic [3:0] I_ADCTLA = 4'd8;
  localparam logic [3:0] I_OPTION = 4'd9;
  localparam logic [3:0] I_PORTDIR = 4'd10;
  localparam logic [3:0] I_PIEN = 4'd11;
  localparam logic [3:0] I_PWRFLAGS = 4'd12;
  localparam logic [3:0] I_OSCTRIM = 4'd13;
  localparam logic [3:0] I_ADCTLB = 4'd14;

  localparam int STATUS_PAGE_BIT = 5;
  localparam int STATUS_Z_BIT = 2;
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] SFR_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Instruction subset and bus map
  // ---------------------------------------------------------------
  localparam logic [6:0] OP_MOVWF = 7'b0000001;
  localparam logic [6:0] OP_CLRF = 7'b0000011;
  localparam logic [5:0] OP_ADDWF = 6'b000111;
  localparam logic [5:0] OP_MOVF = 6'b001000;
  localparam logic [3:0] OP_MOVLW = 4'b1100;
  localparam logic [2:0] OP_GOTO = 3'b101;
  localparam logic [13:0] INSTR_NOP = 14'h0000;

  localparam logic [11:0] BUS_CTRL = 12'h400;
  localparam logic [11:0] BUS_PROG_ADDR = 12'h404;
  localparam logic [11:0] BUS_PROG_DATA = 12'h408;
  localparam logic [11:0] BUS_STATE = 12'h40C;

  localparam logic [2:0] K_NONE = 3'd0;
  localparam logic [2:0] K_IND = 3'd1;
  localparam logic [2:0] K_PCL = 3'd2;
  localparam logic [2:0] K_SFR = 3'd3;
  localparam logic [2:0] K_GPR = 3'd4;

  typedef struct packed {
    logic [2:0] kind;
    logic [6:0] idx;
  } qpc_cell_t;

  function automatic qpc_cell_t qpc_decode(input logic [7:0] a);
    qpc_cell_t c;
    logic [7:0] m;
    logic [7:0] d;
    c = '{kind: K_NONE, idx: 7'd0};
    m = (a >= A_MIRROR_LO) ? (a & BANK_MASK) : a; // RQ12
    if ((m & BANK_MASK) inside {A_INDIRECT, A_PCL, A_STATUS, A_POINTER, A_LATCH, A_INTCTL}) begin
      m = m & BANK_MASK; // RQ12
    end
    unique case (m)
      A_INDIRECT: c.kind = K_IND;
      A_PCL: c.kind = K_PCL;
      A_TIMER0: c = '{kind: K_SFR, idx: {3'd0, I_TIMER0}};
      A_STATUS: c = '{kind: K_SFR, idx: {3'd0, I_STATUS}};
      A_POINTER: c = '{kind: K_SFR, idx: {3'd0, I_POINTER}};
      A_PORT: c = '{kind: K_SFR, idx: {3'd0, I_PORT}};
      A_LATCH: c = '{kind: K_SFR, idx: {3'd0, I_LATCH}};
      A_INTCTL: c = '{kind: K_SFR, idx: {3'd0, I_INTCTL}};
      A_PIFLAGS: c = '{kind: K_SFR, idx: {3'd0, I_PIFLAGS}};
      A_ADC_RESULT: c = '{kind: K_SFR, idx: {3'd0, I_ADC_RESULT}};
      A_ADCTLA: c = '{kind: K_SFR, idx: {3'd0, I_ADCTLA}};
      A_OPTION: c = '{kind: K_SFR, idx: {3'd0, I_OPTION}};
      A_PORTDIR: c = '{kind: K_SFR, idx: {3'd0, I_PORTDIR}};
      A_PIEN: c = '{kind: K_SFR, idx: {3'd0, I_PIEN}};
      A_PWRFLAGS: c = '{kind: K_SFR, idx: {3'd0, I_PWRFLAGS}};
      A_OSCTRIM: c = '{kind: K_SFR, idx: {3'd0, I_OSCTRIM}};
      A_ADCTLB: c = '{kind: K_SFR, idx: {3'd0, I_ADCTLB}};
      default: begin
        if (m >= A_GPR0_LO && m <= A_GPR0_HI) begin
          d = m - A_GPR0_LO; // RQ13
          c = '{kind: K_GPR, idx: d[6:0]};
        end else if (m >= A_GPR1_LO && m <= A_GPR1_HI) begin
          d = m - A_GPR1_LO; // RQ13
          c = '{kind: K_GPR, idx: d[6:0] + GPR1_BASE};
        end
      end
    endcase
    return c;
  endfunction

  // An indirect access through the indirect location itself finds no cell.
  function automatic qpc_cell_t qpc_resolve(input logic [7:0] a, input logic [7:0] ptr);
    qpc_cell_t c;
    c = qpc_decode(a);
    if (c.kind == K_IND) begin
      c = qpc_decode(ptr); // RQ8
      if (c.kind == K_IND) begin
        c.kind = K_NONE;
      end
    end
    return c;
  endfunction

endpackage

// ===== verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qpc_pkg::*;

  // ---------------------------------------------------------------
  // Design hookup
  // ---------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  qpc_phase_t phase;
  int bad_count;
  int tests_run;
  int cycles;
  logic [31:0] rd;

  qpc_core #(.PROG_DEPTH(1024)) u_qpc_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase(phase)
  );

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
  end

  always #5 hclk = ~hclk;

  // A hung handshake would otherwise stall the run for ever.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic read_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_read(a, v);
    check(what, v, exp);
    check("okay response", {31'h0, hresp}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_phases();
    logic [3:0] seq [0:4];
    seq = '{4'b0001, 4'b0010, 4'b0100, 4'b1000, 4'b0001};
    check("phase in reset", {28'h0, phase}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      #1;
      check("phase rotation", {28'h0, phase}, {28'h0, seq[i]});
      @(posedge hclk);
    end
  endtask

  task automatic t_map();
    read_check("status reset", 12'h00C, 32'h18);
    bus_write(12'h20C, 32'h20);
    read_check("status shared", 12'h00C, 32'h38);
    bus_write(12'h00C, 32'h00);
    read_check("status fixed bits", 12'h20C, 32'h18);
    bus_write(12'h080, 32'hFFFF_FF12);
    read_check("bank 0 ram", 12'h080, 32'h12);
    bus_write(12'h280, 32'hA5);
    read_check("bank 1 ram", 12'h280, 32'hA5);
    read_check("bank 0 ram kept", 12'h080, 32'h12);
    bus_write(12'h014, 32'h0F);
    bus_write(12'h214, 32'hF0);
    read_check("port level", 12'h014, 32'h0F);
    read_check("port direction", 12'h214, 32'hF0);
    bus_write(12'h3C0, 32'h77);
    read_check("mirror", 12'h1C0, 32'h77);
    bus_write(12'h018, 32'hFF);
    read_check("empty low", 12'h018, 32'h00);
    bus_write(12'h300, 32'hFF);
    read_check("empty high", 12'h300, 32'h00);
    read_check("unmapped", 12'h500, 32'h00);
  endtask

  task automatic t_indirect();
    bus_write(12'h210, 32'h21);
    bus_write(12'h000, 32'h3C);
    read_check("indirect target", 12'h084, 32'h3C);
    read_check("indirect read", 12'h200, 32'h3C);
    bus_write(12'h010, 32'h00);
    read_check("self pointer", 12'h000, 32'h00);
  endtask

  task automatic t_latch();
    bus_write(12'h028, 32'h01);
    bus_write(12'h008, 32'h05);
    bus_read(12'h40C, rd);
    check("counter from latch", {19'h0, rd[12:0]}, 32'h105);
    read_check("low byte", 12'h208, 32'h05);
    bus_write(12'h028, 32'h00);
    bus_write(12'h008, 32'h00);
  endtask

  // The skipped words would leave their marks in W and 31h if a branch ran them.
  task automatic t_program();
    logic [13:0] prog [0:6];
    int n;
    prog = '{14'h305A, 14'h00B0, 14'h2805, 14'h30FF, 14'h00B1, 14'h07B0, 14'h2806};
    bus_write(12'h0C4, 32'h00);
    bus_write(BUS_PROG_ADDR, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus_write(BUS_PROG_DATA, {18'h0, prog[i]});
    end
    bus_write(BUS_PROG_ADDR, 32'h2);
    read_check("program word", BUS_PROG_DATA, 32'h2805);
    bus_write(BUS_CTRL, 32'h1);
    n = 0;
    do begin
      bus_read(12'h0C0, rd);
      n++;
    end while (rd !== 32'hB4 && n < 100);
    check("add result", rd, 32'hB4);
    bus_write(BUS_CTRL, 32'h0);
    bus_read(BUS_STATE, rd);
    check("working value", {24'h0, rd[23:16]}, 32'h5A);
    check("loop counter", {31'h0, rd[12:0] == 13'd6 || rd[12:0] == 13'd7}, 32'h1);
    read_check("skipped store", 12'h0C4, 32'h00);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    t_phases();
    t_map();
    t_indirect();
    t_latch();
    t_program();
    summarize();
  end

endmodule
